// *** rtl/csbx_pkg.sv ***
// Package of opcodes, flag positions and timing counts for the compare/skip/branch unit
package csbx_pkg;

  // ----------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSBX_OP_NONE,
    CSBX_INDIRECT_CALL_OP,
    CSBX_SUBROUTINE_EXIT_OP,
    CSBX_INTERRUPT_EXIT_OP,
    CSBX_COMPARE_SKIP_EQUAL_OP,
    CSBX_COMPARE_IMMEDIATE_OP,
    CSBX_SKIP_REG_BIT_CLEAR_OP,
    CSBX_SKIP_REG_BIT_SET_OP,
    CSBX_SKIP_IO_BIT_CLEAR_OP,
    CSBX_SKIP_IO_BIT_SET_OP,
    CSBX_BRANCH_FLAG_SET_OP,
    CSBX_BRANCH_FLAG_CLEAR_OP,
    CSBX_BRANCH_NO_CARRY_OP
  } csbx_op_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSBX_ST_IDLE,
    CSBX_ST_CALL_PUSH,
    CSBX_ST_CALL_WAIT,
    CSBX_ST_RET_POP,
    CSBX_ST_RET_WAIT,
    CSBX_ST_RET_LOAD
  } csbx_state_t;

  // ----------------------------------------------------------------
  // Status flag bit positions
  // ----------------------------------------------------------------
  localparam int CSBX_FLAG_C = 0;
  localparam int CSBX_FLAG_Z = 1;
  localparam int CSBX_FLAG_N = 2;
  localparam int CSBX_FLAG_V = 3;
  localparam int CSBX_FLAG_H = 5;
  localparam int CSBX_FLAG_I = 7;

  // ----------------------------------------------------------------
  // Widths, reset values and program counter steps
  // ----------------------------------------------------------------
  localparam int CSBX_PC_W = 16;
  localparam int CSBX_OFS_W = 7;
  localparam logic [15:0] CSBX_PC_RESET = 16'h0000;
  localparam logic [7:0] CSBX_FLAGS_RESET = 8'h00;
  localparam logic [15:0] CSBX_STEP_ONE = 16'h0001;
  localparam logic [15:0] CSBX_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] CSBX_SKIP_LONG = 16'h0003;
  localparam int CSBX_CALL_CYCLES = 3;
  localparam int CSBX_RET_CYCLES = 4;

endpackage

// *** rtl/csbx_exec.sv ***
// Execution unit for indirect call, returns, compares, skips and flag branches
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Indirect call pushes return, loads Z, three cycles
// - Equal registers skip: program counter plus 2/3
// - Compare immediate updates Z N V C H only
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips, flags untouched
// - I/O bit set skips, flags untouched
// - Selected flag set branches by offset plus one
// - Selected flag clear branches by offset plus one
// - Carry clear branches by offset plus one
module csbx_exec
  import csbx_pkg::*;
#(
  parameter int PC_W = CSBX_PC_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire csbx_op_t op_code,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm_val,
  input wire logic [7:0] io_val,
  input wire logic [2:0] bit_sel,
  input wire logic [CSBX_OFS_W-1:0] rel_ofs,
  input wire logic next_two_word,
  input wire logic [7:0] status_flags,
  input wire logic [PC_W-1:0] z_ptr,
  input wire logic [PC_W-1:0] stack_data,
  output logic busy_ff,
  output logic done_ff,
  output logic [PC_W-1:0] pc_out_ff,
  output logic flags_we_ff,
  output logic [7:0] flags_out_ff,
  output logic push_req_ff,
  output logic [PC_W-1:0] push_data_ff,
  output logic pop_req_ff
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Skip distance depends on the length of the instruction jumped over
  function automatic logic [PC_W-1:0] skip_step(input logic two_word);
    skip_step = two_word ? PC_W'(CSBX_SKIP_LONG) : PC_W'(CSBX_SKIP_SHORT);
  endfunction

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  // Call and both returns go through the multi-cycle sequencer
  function automatic logic is_call(input csbx_op_t op);
    is_call = (op == CSBX_INDIRECT_CALL_OP);
  endfunction

  function automatic logic is_return(input csbx_op_t op);
    is_return = (op == CSBX_SUBROUTINE_EXIT_OP) || (op == CSBX_INTERRUPT_EXIT_OP);
  endfunction

  // The empty code is taken but answers nothing
  function automatic logic is_single(input csbx_op_t op);
    is_single = (op != CSBX_OP_NONE) && !is_call(op) && !is_return(op);
  endfunction

  csbx_state_t state_ff;
  logic take_op;
  logic skip_hit;
  logic branch_hit;
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_rel;
  logic [PC_W-1:0] nxt_pc;
  logic [7:0] cmp_res;
  logic [7:0] nxt_flags;
  logic flags_touch;
  logic call_take;
  logic ret_take;
  logic single_take;
  logic seq_last;
  logic half_borrow;
  logic full_borrow;
  logic sub_ovf;

  assign take_op = op_valid && (state_ff == CSBX_ST_IDLE);
  assign call_take = take_op && is_call(op_code);
  assign ret_take = take_op && is_return(op_code);
  assign single_take = take_op && is_single(op_code);
  // Last cycle of a call or return: the answer leaves and the sequencer frees up
  assign seq_last = (state_ff == CSBX_ST_CALL_WAIT) || (state_ff == CSBX_ST_RET_LOAD);
  assign pc_seq = pc_in + PC_W'(CSBX_STEP_ONE);
  // Offset is sign extended before the add so backward branches wrap correctly
  assign pc_rel = pc_in + PC_W'({{(PC_W-CSBX_OFS_W){rel_ofs[CSBX_OFS_W-1]}}, rel_ofs})
                  + PC_W'(CSBX_STEP_ONE);
  assign cmp_res = rd_val - imm_val;

  // ----------------------------------------------------------------
  // Borrow and overflow of the compare subtraction
  // ----------------------------------------------------------------
  // Borrows out of bits 3 and 7; the compare keeps no difference, only these
  assign half_borrow = (!rd_val[3] && imm_val[3]) || (imm_val[3] && cmp_res[3])
                       || (cmp_res[3] && !rd_val[3]);
  assign full_borrow = (!rd_val[7] && imm_val[7]) || (imm_val[7] && cmp_res[7])
                       || (cmp_res[7] && !rd_val[7]);
  assign sub_ovf = (rd_val[7] && !imm_val[7] && !cmp_res[7])
                   || (!rd_val[7] && imm_val[7] && cmp_res[7]);

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  always_comb begin
    skip_hit = 1'b0;
    branch_hit = 1'b0;
    case (op_code)
      CSBX_COMPARE_SKIP_EQUAL_OP: skip_hit = (rd_val == rr_val);
      CSBX_SKIP_REG_BIT_CLEAR_OP: skip_hit = !rr_val[bit_sel];
      CSBX_SKIP_REG_BIT_SET_OP: skip_hit = rr_val[bit_sel];
      CSBX_SKIP_IO_BIT_CLEAR_OP: skip_hit = !io_val[bit_sel];
      CSBX_SKIP_IO_BIT_SET_OP: skip_hit = io_val[bit_sel];
      CSBX_BRANCH_FLAG_SET_OP: branch_hit = status_flags[bit_sel];
      CSBX_BRANCH_FLAG_CLEAR_OP: branch_hit = !status_flags[bit_sel];
      CSBX_BRANCH_NO_CARRY_OP: branch_hit = !status_flags[CSBX_FLAG_C];
      default: begin
        skip_hit = 1'b0;
        branch_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next program counter for single-cycle operations
  // ----------------------------------------------------------------
  always_comb begin
    if (skip_hit) begin
      nxt_pc = pc_in + skip_step(next_two_word);
    end else if (branch_hit) begin
      nxt_pc = pc_rel;
    end else begin
      nxt_pc = pc_seq;
    end
  end

  // ----------------------------------------------------------------
  // Compare flags
  // ----------------------------------------------------------------
  // Only the compare updates flags here; skips and branches leave them alone
  always_comb begin
    nxt_flags = status_flags;
    flags_touch = 1'b0;
    if (op_code == CSBX_COMPARE_IMMEDIATE_OP) begin
      flags_touch = 1'b1;
      nxt_flags[CSBX_FLAG_H] = half_borrow;
      nxt_flags[CSBX_FLAG_V] = sub_ovf;
      nxt_flags[CSBX_FLAG_N] = cmp_res[7];
      nxt_flags[CSBX_FLAG_Z] = (cmp_res == 8'h00);
      nxt_flags[CSBX_FLAG_C] = full_borrow;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer for the multi-cycle operations
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= CSBX_ST_IDLE;
    end else begin
      case (state_ff)
        CSBX_ST_IDLE: begin
          if (call_take) begin
            state_ff <= CSBX_ST_CALL_PUSH;
          end else if (ret_take) begin
            state_ff <= CSBX_ST_RET_POP;
          end
        end
        CSBX_ST_CALL_PUSH: state_ff <= CSBX_ST_CALL_WAIT;
        CSBX_ST_CALL_WAIT: state_ff <= CSBX_ST_IDLE;
        CSBX_ST_RET_POP: state_ff <= CSBX_ST_RET_WAIT;
        CSBX_ST_RET_WAIT: state_ff <= CSBX_ST_RET_LOAD;
        CSBX_ST_RET_LOAD: state_ff <= CSBX_ST_IDLE;
        default: state_ff <= CSBX_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Return bookkeeping
  // ----------------------------------------------------------------
  // Operation held so the interrupt return still knows itself after op_code moves on
  logic ret_irq_ff;
  logic [PC_W-1:0] ret_pc_ff;
  logic irq_load;

  // Interrupt return rewrites the flags in its last cycle only
  assign irq_load = (state_ff == CSBX_ST_RET_LOAD) && ret_irq_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ret_irq_ff <= 1'b0;
    end else if (take_op) begin
      ret_irq_ff <= (op_code == CSBX_INTERRUPT_EXIT_OP);
    end
  end

  // Stack word is sampled a full cycle after the pop request for slow stack memory
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ret_pc_ff <= CSBX_PC_RESET;
    end else if (state_ff == CSBX_ST_RET_WAIT) begin
      ret_pc_ff <= stack_data;
    end
  end

  // ----------------------------------------------------------------
  // Stack requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      push_req_ff <= 1'b0;
    end else begin
      push_req_ff <= call_take;
    end
  end

  // Return address is the word after the call
  always_ff @(posedge clk) begin
    if (!resetn) begin
      push_data_ff <= CSBX_PC_RESET;
    end else if (call_take) begin
      push_data_ff <= pc_seq;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pop_req_ff <= 1'b0;
    end else begin
      pop_req_ff <= ret_take;
    end
  end

  // ----------------------------------------------------------------
  // Busy flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
    end else if (take_op) begin
      busy_ff <= call_take || ret_take;
    end else if (seq_last) begin
      busy_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= seq_last || single_take;
    end
  end

  // Held between answers so the fetch side may read it late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_out_ff <= CSBX_PC_RESET;
    end else if (state_ff == CSBX_ST_CALL_WAIT) begin
      pc_out_ff <= z_ptr;
    end else if (state_ff == CSBX_ST_RET_LOAD) begin
      pc_out_ff <= ret_pc_ff;
    end else if (single_take) begin
      pc_out_ff <= nxt_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_we_ff <= 1'b0;
    end else begin
      flags_we_ff <= irq_load || (take_op && flags_touch);
    end
  end

  // Skips and branches never raise the write, so their flags stay as they were
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_out_ff <= CSBX_FLAGS_RESET;
    end else if (irq_load) begin
      flags_out_ff <= status_flags | (8'h01 << CSBX_FLAG_I);
    end else if (take_op && flags_touch) begin
      flags_out_ff <= nxt_flags;
    end
  end

endmodule // csbx_exec

`default_nettype wire

// *** bench/csbx_exec_monitor.sv ***
// Port checker of the compare/skip/branch execution unit
`timescale 1ns/1ns
`default_nettype none
module csbx_exec_monitor
  import csbx_pkg::*;
#(
  parameter int PC_W = CSBX_PC_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire csbx_op_t op_code,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [7:0] imm_val,
  input wire logic next_two_word,
  input wire logic [7:0] status_flags,
  input wire logic [PC_W-1:0] z_ptr,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic [PC_W-1:0] pc_out_ff,
  input wire logic flags_we_ff,
  input wire logic [7:0] flags_out_ff,
  input wire logic push_req_ff,
  input wire logic [PC_W-1:0] push_data_ff,
  input wire logic pop_req_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Busy stands for the sequencer: high from the edge after a call/return take to its done
  logic tk;
  assign tk = op_valid && !busy_ff;
  a_call_push: assert property (tk && op_code == CSBX_INDIRECT_CALL_OP |=>
    push_req_ff && push_data_ff == $past(pc_in) + 1'b1) else $error("call push wrong");
  a_call_time: assert property (tk && op_code == CSBX_INDIRECT_CALL_OP |->
    ##1 busy_ff [*2] ##1 (done_ff && !busy_ff && pc_out_ff == z_ptr)) else $error("call end");
  a_ret_pop: assert property (tk && op_code inside {CSBX_SUBROUTINE_EXIT_OP,
    CSBX_INTERRUPT_EXIT_OP} |=> pop_req_ff ##1 !pop_req_ff ##2 done_ff) else $error("ret seq");
  a_interrupt_exit_op_ie: assert property (tk && op_code == CSBX_INTERRUPT_EXIT_OP |->
    ##4 flags_we_ff && flags_out_ff[CSBX_FLAG_I]) else $error("interrupt_exit_op enable");
  a_eq_skip: assert property (tk && op_code == CSBX_COMPARE_SKIP_EQUAL_OP &&
    rd_val == rr_val |=> done_ff && pc_out_ff == $past(pc_in) +
    ($past(next_two_word) ? CSBX_SKIP_LONG : CSBX_SKIP_SHORT)) else $error("equal skip");
  a_cpi_keep: assert property (tk && op_code == CSBX_COMPARE_IMMEDIATE_OP |=>
    flags_we_ff && flags_out_ff[CSBX_FLAG_Z] == ($past(rd_val) == $past(imm_val)) &&
    flags_out_ff[7:6] == $past(status_flags[7:6])) else $error("cpi flags");
  a_io_flags: assert property (tk && op_code inside {CSBX_SKIP_IO_BIT_CLEAR_OP,
    CSBX_SKIP_IO_BIT_SET_OP} |=> done_ff && !flags_we_ff) else $error("io skip flags");
  a_nc_fall: assert property (tk && op_code == CSBX_BRANCH_NO_CARRY_OP &&
    status_flags[CSBX_FLAG_C] |=> pc_out_ff == $past(pc_in) + 1'b1) else $error("carry fall");
  c_call: cover property (tk && op_code == CSBX_INDIRECT_CALL_OP);
  c_interrupt_exit_op: cover property (tk && op_code == CSBX_INTERRUPT_EXIT_OP);
  c_cpi: cover property (tk && op_code == CSBX_COMPARE_IMMEDIATE_OP);
endmodule // csbx_exec_monitor
bind csbx_exec csbx_exec_monitor #(.PC_W(PC_W)) u_mon (.clk(clk), .resetn(resetn),
  .op_valid(op_valid), .op_code(op_code), .pc_in(pc_in), .rd_val(rd_val), .rr_val(rr_val),
  .imm_val(imm_val), .next_two_word(next_two_word), .status_flags(status_flags), .z_ptr(z_ptr),
  .busy_ff(busy_ff), .done_ff(done_ff), .pc_out_ff(pc_out_ff), .flags_we_ff(flags_we_ff),
  .flags_out_ff(flags_out_ff), .push_req_ff(push_req_ff), .push_data_ff(push_data_ff),
  .pop_req_ff(pop_req_ff));
`default_nettype wire

// *** bench/test_compare_skip_branch_exec.sv ***
// Self-checking bench of the compare/skip/branch execution unit
`timescale 1ns/1ns
`default_nettype none
module test_compare_skip_branch_exec import csbx_pkg::*; ;
  logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, next_two_word = 1'b0;
  csbx_op_t op_code = CSBX_OP_NONE;
  logic [15:0] pc_in = 16'h0000, z_ptr = 16'h0000, stack_data = 16'h0000;
  logic [7:0] rd_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00, io_val = 8'h00;
  logic [7:0] status_flags = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [6:0] rel_ofs = 7'h00;
  logic busy_ff, done_ff, flags_we_ff, push_req_ff, pop_req_ff;
  logic [15:0] pc_out_ff, push_data_ff;
  logic [7:0] flags_out_ff;
  logic [24:0] exp_q[$];
  logic [31:0] seed = 32'h8d9f281c;
  int miscompares = 0, tests_run = 0, cyc = 0, seq_len = 0, seq_exp = 0;
  always #4 clk = ~clk;
  csbx_exec uut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .pc_in(pc_in), .rd_val(rd_val), .rr_val(rr_val), .imm_val(imm_val), .io_val(io_val),
    .bit_sel(bit_sel), .rel_ofs(rel_ofs), .next_two_word(next_two_word),
    .status_flags(status_flags), .z_ptr(z_ptr), .stack_data(stack_data), .busy_ff(busy_ff),
    .done_ff(done_ff), .pc_out_ff(pc_out_ff), .flags_we_ff(flags_we_ff),
    .flags_out_ff(flags_out_ff), .push_req_ff(push_req_ff), .push_data_ff(push_data_ff),
    .pop_req_ff(pop_req_ff));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // ----------------------------------------------------------------
  // Reference model on the inputs being presented
  // ----------------------------------------------------------------
  function automatic logic [24:0] model();
    logic [15:0] e, sk, br;
    logic [7:0] f, r;
    logic w;
    r = rd_val - imm_val;
    f = status_flags;
    w = 1'b0;
    e = pc_in + CSBX_STEP_ONE;
    sk = pc_in + (next_two_word ? CSBX_SKIP_LONG : CSBX_SKIP_SHORT);
    br = pc_in + {{9{rel_ofs[6]}}, rel_ofs} + CSBX_STEP_ONE;
    case (op_code)
      CSBX_INDIRECT_CALL_OP: e = z_ptr;
      CSBX_SUBROUTINE_EXIT_OP: e = stack_data;
      CSBX_INTERRUPT_EXIT_OP: begin
        e = stack_data;
        w = 1'b1;
        f[7] = 1'b1;
      end
      CSBX_COMPARE_SKIP_EQUAL_OP: if (rd_val == rr_val) e = sk;
      CSBX_COMPARE_IMMEDIATE_OP: begin
        w = 1'b1;
        f[0] = rd_val < imm_val;
        f[1] = r == 8'h00;
        f[2] = r[7];
        f[3] = (rd_val[7] ^ imm_val[7]) & (rd_val[7] ^ r[7]);
        f[5] = rd_val[3:0] < imm_val[3:0];
      end
      CSBX_SKIP_REG_BIT_CLEAR_OP: if (!rr_val[bit_sel]) e = sk;
      CSBX_SKIP_REG_BIT_SET_OP: if (rr_val[bit_sel]) e = sk;
      CSBX_SKIP_IO_BIT_CLEAR_OP: if (!io_val[bit_sel]) e = sk;
      CSBX_SKIP_IO_BIT_SET_OP: if (io_val[bit_sel]) e = sk;
      CSBX_BRANCH_FLAG_SET_OP: if (status_flags[bit_sel]) e = br;
      CSBX_BRANCH_FLAG_CLEAR_OP: if (!status_flags[bit_sel]) e = br;
      CSBX_BRANCH_NO_CARRY_OP: if (!status_flags[0]) e = br;
      default: ;
    endcase
    return {w, w ? f : 8'h00, e};
  endfunction
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Result watcher: oldest note against each done pulse
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (resetn && done_ff === 1'b1) begin
      tests_run++;
      if (exp_q.size() == 0 || {flags_we_ff, flags_we_ff ? flags_out_ff : 8'h00,
          pc_out_ff} !== exp_q.pop_front()) begin
        miscompares++;
        $display("FAIL %0t: result mismatch", $time);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      $display("FAIL %0t: timeout", $time);
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Random driver, back to back singles, gaps, held operands
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (400) begin
      @(negedge clk);
      seed = xs(seed);
      {pc_in, rd_val, rr_val} = seed;
      seed = xs(seed);
      {z_ptr, imm_val, io_val} = seed;
      seed = xs(seed);
      {stack_data, status_flags, rel_ofs, next_two_word} = seed;
      seed = xs(seed);
      bit_sel = seed[2:0];
      // Equal operands are rare at random, so force them now and then
      if (seed[12:10] == 3'h0) rr_val = rd_val;
      op_code = csbx_op_t'(seed[7:4] % 4'hd);
      op_valid = seed[8] | seed[9];
      if (op_valid && op_code != CSBX_OP_NONE) exp_q.push_back(model());
      if (op_valid && op_code inside {CSBX_INDIRECT_CALL_OP, CSBX_SUBROUTINE_EXIT_OP,
          CSBX_INTERRUPT_EXIT_OP}) begin
        @(negedge clk);
        op_valid = 1'b0;
        seq_len = 1;
        repeat (6) if (done_ff !== 1'b1) begin
          @(negedge clk);
          seq_len++;
        end
        seq_exp = (op_code == CSBX_INDIRECT_CALL_OP) ? CSBX_CALL_CYCLES : CSBX_RET_CYCLES;
        tests_run++;
        if (seq_len != seq_exp) begin
          miscompares++;
          $display("FAIL %0t: sequence length wrong", $time);
        end
      end
    end
    @(negedge clk);
    op_valid = 1'b0;
    repeat (6) @(negedge clk);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("FAIL %0t: results missing", $time);
    end
    close_out();
  end
endmodule // test_compare_skip_branch_exec
`default_nettype wire
